// *** hri_pkg.sv ***
// shared constants for the host register interface, both ends
package hri_pkg;
    // ----------
    // register indices on the parallel bus
    // ----------
    localparam logic [7:0] IDX_SOFTWARE_RESET_PLL_APPLY = 8'h00;
    localparam logic [7:0] IDX_CHIP_CONFIGURATION = 8'h01;
    localparam logic [7:0] IDX_MEMORY_ACCESS_CONTROL = 8'h02;
    localparam logic [7:0] IDX_INPUT_CONTROL = 8'h03;
    // ----------
    // reset values and field positions
    // ----------
    localparam logic [7:0] RST_CHIP_CONFIGURATION = 8'h48;
    localparam logic [7:0] RST_MEMORY_ACCESS_CONTROL = 8'h00;
    localparam logic [7:0] RST_INPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam int SRR_PLL_APPLY = 7;
    localparam int SRR_SOFT_RESET = 0;
    localparam int CCR_PLL_READY = 7;
    localparam int CCR_WAIT_MASK = 6;
    localparam int CCR_KEYSCAN = 5;
    localparam int CCR_I2C = 2;
    localparam int CCR_SPI = 1;
    localparam int CCR_BUS16 = 0;
    localparam int ICR_INT_POL = 7;
    localparam int ICR_DEBOUNCE = 6;
    localparam int ST_WFIFO_FULL = 7;
    // writable masks: reserved bits read zero
    localparam logic [7:0] CCR_WR_MASK = 8'h7f;
    localparam logic [7:0] MEMORY_ACCESS_CONTROL_WR_MASK = 8'hf6;
    localparam logic [7:0] ICR_WR_MASK = 8'hf0;
    // ----------
    // field codes
    // ----------
    localparam logic [1:0] PANEL_24 = 2'h0;
    localparam logic [1:0] PANEL_18 = 2'h1;
    localparam logic [1:0] PANEL_16 = 2'h2;
    localparam logic [1:0] PANEL_NONE = 2'h3;
    localparam logic [1:0] FMT_MASK_ALL = 2'h2;
    localparam logic [1:0] FMT_MASK_EVEN = 2'h3;
    localparam logic [1:0] TRIG_LOW = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_HIGH = 2'h2;
    localparam logic [1:0] TRIG_RISE = 2'h3;
    localparam logic [1:0] BPP_8 = 2'h0;
    localparam logic [1:0] BPP_16 = 2'h1;
    localparam logic [6:0] BURST_8BPP = 7'h40;
    localparam logic [6:0] BURST_16BPP = 7'h20;
    localparam logic [6:0] BURST_24BPP = 7'h10;
    // ----------
    // timing
    // ----------
    localparam int CLK_NS = 100;
    localparam int DEBOUNCE_CYC = 1024;
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // ----------
    // host controller command encoding and ahb map
    // ----------
    localparam logic [1:0] OP_INDEX_WRITE = 2'h0;
    localparam logic [1:0] OP_DATA_WRITE = 2'h1;
    localparam logic [1:0] OP_STATUS_READ = 2'h2;
    localparam logic [1:0] OP_DATA_READ = 2'h3;
    localparam logic [7:0] AHB_CMD = 8'h00;
    localparam logic [7:0] AHB_STATUS = 8'h04;
    localparam int CMD_GUARD = 10;
endpackage

// *** hri_bus_if.sv ***
// parallel host bus joining controller and device
`timescale 1ns/1ps
interface hri_bus_if;
    logic cs_n;
    logic register_select_line;
    logic rd_n;
    logic wr_n;
    logic wait_n;
    logic [7:0] host_dout;
    logic host_doe;
    logic [7:0] dev_dout;
    logic dev_doe;
    logic [7:0] data_bus;

    // wire level of the shared data bus; pulled high when nobody drives
    assign data_bus = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hff);

    modport device (
        input cs_n, register_select_line, rd_n, wr_n, data_bus,
        output wait_n, dev_dout, dev_doe
    );
    modport host (
        output cs_n, register_select_line, rd_n, wr_n, host_dout, host_doe,
        input wait_n, data_bus
    );
endinterface

// *** hri_device.sv ***
// device end: register file, status, pin-function and interrupt control
// Behaviour
// RULE_01: index write then data write stores byte
// RULE_02: status read returns read-only status register
// RULE_03: data read returns indexed register contents
// RULE_04: eight-bit registers with defaults and access
// RULE_05: status bit 7 shows write fifo full
// RULE_06: status bit 6 write fifo empty, burst
// RULE_07: bits 5/4 read fifo full/empty, burst
// RULE_08: status bit 3 shows core task busy
// RULE_09: status bit 2 shows display memory ready
// RULE_10: status bit 1 inhibit, reset or power-save
// RULE_11: status bit 0 interrupt; polarity from control
// RULE_12: pll apply write; pll ready readback
// RULE_13: soft reset pulse, self clears, warning readback
// RULE_14: wait masking on chip select deassert
// RULE_15: panel width selection and spare pins
// RULE_16: i2c enable, overrides key pin zero
// RULE_17: serial flash pins gpio or spi
// RULE_18: bus width forced eight when serial/initial
// RULE_19: image data format masking selection
// RULE_20: read/write scan order, ignored when linear
// RULE_21: optional 1024-clock interrupt input debounce
// RULE_22: interrupt input trigger type selection
// RULE_23: index stays until next index write
`timescale 1ns/1ps
module hri_device #(
    parameter int DEBOUNCE = hri_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // parallel host bus
    hri_bus_if.device bus,
    // core status
    input wire logic wfifo_full,
    input wire logic wfifo_empty,
    input wire logic rfifo_full,
    input wire logic rfifo_empty,
    input wire logic core_busy,
    input wire logic display_memory_ready,
    input wire logic inhibit_state,
    input wire logic pll_switched,
    input wire logic warning_flag,
    input wire logic host_busy,
    input wire logic serial_host_sel,
    input wire logic initial_display_run,
    input wire logic linear_canvas,
    input wire logic [1:0] color_depth,
    // interrupts
    input wire logic irq_request,
    input wire logic external_interrupt_input,
    output logic int_pin,
    output logic ext_int_event,
    // control outputs
    output logic pll_apply,
    output logic soft_reset,
    output logic [1:0] panel_width,
    output logic [23:0] panel_spare_pins,
    output logic keyscan_en,
    output logic i2c_en,
    output logic key_zero_is_i2c,
    output logic spi_en,
    output logic bus16,
    output logic mask_high_all,
    output logic mask_high_even,
    output logic [1:0] read_order,
    output logic [1:0] write_order,
    output logic [6:0] burst_pixels
);
    // ----------
    // host cycle decode
    // ----------
    logic wr_n_q;
    logic wr_take;
    logic rd_act;
    logic [7:0] index_r;
    logic [7:0] ccr_r;
    logic [7:0] memory_access_control_r;
    logic [7:0] icr_r;
    logic [7:0] status;
    logic [7:0] rd_mux;
    logic [7:0] dout_r;
    logic pll_apply_r;
    logic soft_reset_r;
    logic [1:0] soft_hold_r;

    // write taken on the falling strobe, data is stable from then on
    assign wr_take = wr_n_q & ~bus.wr_n & ~bus.cs_n;
    assign rd_act = ~bus.rd_n & ~bus.cs_n;

    always_ff @(posedge clock)
    begin
        if (rst)
            wr_n_q <= 1'b1;
        else
            wr_n_q <= bus.wr_n;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            index_r <= hri_pkg::RST_INDEX;
        else if (wr_take && !bus.register_select_line)
            index_r <= bus.data_bus; // [RULE_01] [RULE_23]
    end

    // ----------
    // register file
    // ----------
    logic data_wr;
    assign data_wr = wr_take & bus.register_select_line; // [RULE_01]

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ccr_r <= hri_pkg::RST_CHIP_CONFIGURATION;
            memory_access_control_r <= hri_pkg::RST_MEMORY_ACCESS_CONTROL;
            icr_r <= hri_pkg::RST_INPUT_CONTROL;
        end
        else if (data_wr)
        begin
            // only writable bits load; status has no index here [RULE_02] [RULE_04]
            case (index_r)
                hri_pkg::IDX_CHIP_CONFIGURATION:
                    ccr_r <= bus.data_bus & hri_pkg::CCR_WR_MASK;
                hri_pkg::IDX_MEMORY_ACCESS_CONTROL:
                    memory_access_control_r <= bus.data_bus & hri_pkg::MEMORY_ACCESS_CONTROL_WR_MASK;
                hri_pkg::IDX_INPUT_CONTROL:
                    icr_r <= bus.data_bus & hri_pkg::ICR_WR_MASK;
                default:
                    ccr_r <= ccr_r;
            endcase
        end
    end

    // pll apply and soft reset are single-cycle pulses, bits self clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pll_apply_r <= 1'b0;
            soft_reset_r <= 1'b0;
        end
        else
        begin
            pll_apply_r <= data_wr && index_r == hri_pkg::IDX_SOFTWARE_RESET_PLL_APPLY
                && bus.data_bus[hri_pkg::SRR_PLL_APPLY]; // [RULE_12]
            soft_reset_r <= data_wr && index_r == hri_pkg::IDX_SOFTWARE_RESET_PLL_APPLY
                && bus.data_bus[hri_pkg::SRR_SOFT_RESET]; // [RULE_13]
        end
    end

    // inhibit shown for a short while after a soft reset
    always_ff @(posedge clock)
    begin
        if (rst)
            soft_hold_r <= 2'h0;
        else if (soft_reset_r)
            soft_hold_r <= 2'h3;
        else if (soft_hold_r != 2'h0)
            soft_hold_r <= soft_hold_r - 2'h1;
    end

    assign pll_apply = pll_apply_r;
    assign soft_reset = soft_reset_r;

    // ----------
    // status and read data
    // ----------
    logic int_active;

    always_comb
    begin
        status = {wfifo_full, wfifo_empty, rfifo_full, rfifo_empty, // [RULE_05] [RULE_06] [RULE_07]
                  core_busy, // [RULE_08]
                  display_memory_ready, // [RULE_09]
                  inhibit_state | (soft_hold_r != 2'h0), // [RULE_10]
                  int_active}; // [RULE_11]
        case (index_r)
            hri_pkg::IDX_SOFTWARE_RESET_PLL_APPLY:
                rd_mux = {pll_switched, 6'h00, warning_flag}; // [RULE_12] [RULE_13]
            hri_pkg::IDX_CHIP_CONFIGURATION:
                rd_mux = {pll_switched, ccr_r[6:1], bus16};
            hri_pkg::IDX_MEMORY_ACCESS_CONTROL:
                rd_mux = memory_access_control_r;
            hri_pkg::IDX_INPUT_CONTROL:
                rd_mux = icr_r;
            default:
                rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            dout_r <= 8'h00;
        else if (!bus.register_select_line)
            dout_r <= status; // [RULE_02]
        else
            dout_r <= rd_mux; // [RULE_03]
    end

    assign bus.dev_dout = dout_r;
    assign bus.dev_doe = rd_act;
    // mask set: released with chip select; clear: held while busy [RULE_14]
    assign bus.wait_n = ~(host_busy & (~ccr_r[hri_pkg::CCR_WAIT_MASK] | ~bus.cs_n));

    // ----------
    // pin function and memory access controls
    // ----------
    always_comb
    begin
        panel_width = ccr_r[4:3]; // [RULE_15]
        case (ccr_r[4:3])
            hri_pkg::PANEL_24: panel_spare_pins = 24'h000000;
            hri_pkg::PANEL_18: panel_spare_pins = 24'hfc0000;
            hri_pkg::PANEL_16: panel_spare_pins = 24'hff0000;
            hri_pkg::PANEL_NONE: panel_spare_pins = 24'hffffff;
            default: panel_spare_pins = 24'h000000;
        endcase
        keyscan_en = ccr_r[hri_pkg::CCR_KEYSCAN];
        i2c_en = ccr_r[hri_pkg::CCR_I2C]; // [RULE_16]
        key_zero_is_i2c = ccr_r[hri_pkg::CCR_I2C] & ccr_r[hri_pkg::CCR_KEYSCAN]; // [RULE_16]
        spi_en = ccr_r[hri_pkg::CCR_SPI]; // [RULE_17]
        bus16 = ccr_r[hri_pkg::CCR_BUS16] & ~serial_host_sel & ~initial_display_run; // [RULE_18]
        mask_high_all = memory_access_control_r[7:6] == hri_pkg::FMT_MASK_ALL; // [RULE_19]
        mask_high_even = memory_access_control_r[7:6] == hri_pkg::FMT_MASK_EVEN; // [RULE_19]
        read_order = linear_canvas ? 2'h0 : memory_access_control_r[5:4]; // [RULE_20]
        write_order = linear_canvas ? 2'h0 : memory_access_control_r[2:1]; // [RULE_20]
        case (color_depth)
            hri_pkg::BPP_8: burst_pixels = hri_pkg::BURST_8BPP; // [RULE_06] [RULE_07]
            hri_pkg::BPP_16: burst_pixels = hri_pkg::BURST_16BPP;
            default: burst_pixels = hri_pkg::BURST_24BPP;
        endcase
    end

    // ----------
    // interrupt pin and external interrupt input
    // ----------
    logic [10:0] deb_cnt_r;
    logic deb_r;
    logic ext_level;
    logic ext_prev_r;
    logic ext_evt_r;
    logic int_pin_r;

    // debounce: input must hold a new level for the full count
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            deb_cnt_r <= 11'h000;
            deb_r <= 1'b1;
        end
        else if (external_interrupt_input == deb_r)
            deb_cnt_r <= 11'h000;
        else if (deb_cnt_r == 11'(DEBOUNCE - 1))
        begin
            deb_r <= external_interrupt_input; // [RULE_21]
            deb_cnt_r <= 11'h000;
        end
        else
            deb_cnt_r <= deb_cnt_r + 11'h001;
    end

    assign ext_level = icr_r[hri_pkg::ICR_DEBOUNCE] ? deb_r : external_interrupt_input; // [RULE_21]

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ext_prev_r <= 1'b1;
            ext_evt_r <= 1'b0;
        end
        else
        begin
            ext_prev_r <= ext_level;
            case (icr_r[5:4]) // [RULE_22]
                hri_pkg::TRIG_LOW: ext_evt_r <= ~ext_level;
                hri_pkg::TRIG_FALL: ext_evt_r <= ext_prev_r & ~ext_level;
                hri_pkg::TRIG_HIGH: ext_evt_r <= ext_level;
                hri_pkg::TRIG_RISE: ext_evt_r <= ~ext_prev_r & ext_level;
                default: ext_evt_r <= 1'b0;
            endcase
        end
    end

    assign ext_int_event = ext_evt_r;

    // polarity applied at the pin only, status bit stays active high
    always_ff @(posedge clock)
    begin
        if (rst)
            int_pin_r <= 1'b1;
        else
            int_pin_r <= icr_r[hri_pkg::ICR_INT_POL] ? irq_request : ~irq_request; // [RULE_11]
    end

    assign int_active = irq_request; // [RULE_11]
    assign int_pin = int_pin_r;
endmodule

// *** hri_host.sv ***
// controller end: ahb-lite command registers driving parallel host cycles
`timescale 1ns/1ps
module hri_host #(
    parameter int STROBE = hri_pkg::STROBE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // parallel host bus
    hri_bus_if.host bus
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD = 4'b1000
    } hri_state_type;

    // ----------
    // ahb-lite slave, zero wait states
    // ----------
    logic ph_wr_r;
    logic [7:0] ph_addr_r;
    logic cmd_go;
    logic busy;
    logic refused_r;
    logic [7:0] rdata_r;
    logic [7:0] status_r;
    hri_state_type state_r;
    logic [1:0] op_r;
    logic [7:0] wdata_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ph_wr_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end
        else if (hready)
        begin
            ph_wr_r <= hsel & htrans[1] & hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    assign busy = state_r != ST_IDLE;
    assign cmd_go = ph_wr_r & (ph_addr_r == hri_pkg::AHB_CMD) & ~busy;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = (ph_addr_r == hri_pkg::AHB_STATUS) ?
        {14'h0000, refused_r, busy, status_r, rdata_r} : 32'h00000000;

    // ----------
    // cycle sequencer
    // ----------
    logic guard_hit;
    // guarded data write refused while last status showed fifo full
    assign guard_hit = hwdata[hri_pkg::CMD_GUARD] & status_r[hri_pkg::ST_WFIFO_FULL]
        & (hwdata[9:8] == hri_pkg::OP_DATA_WRITE); // [RULE_05]

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            op_r <= hri_pkg::OP_INDEX_WRITE;
            wdata_r <= 8'h00;
            cnt_r <= 4'h0;
            refused_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (cmd_go)
                    begin
                        refused_r <= guard_hit;
                        if (!guard_hit)
                        begin
                            op_r <= hwdata[9:8];
                            wdata_r <= hwdata[7:0];
                            state_r <= ST_SETUP;
                        end
                    end
                ST_SETUP:
                begin
                    cnt_r <= 4'(STROBE);
                    state_r <= ST_STROBE;
                end
                ST_STROBE:
                    if (cnt_r > 4'h1)
                        cnt_r <= cnt_r - 4'h1;
                    else if (bus.wait_n)
                        state_r <= ST_HOLD;
                ST_HOLD:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // read data taken on the last strobe cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_r <= 8'h00;
            status_r <= 8'h00;
        end
        else if (state_r == ST_STROBE && cnt_r <= 4'h1 && bus.wait_n)
        begin
            if (op_r == hri_pkg::OP_STATUS_READ)
                status_r <= bus.data_bus; // [RULE_08] [RULE_09] [RULE_12]
            else if (op_r == hri_pkg::OP_DATA_READ)
                rdata_r <= bus.data_bus; // [RULE_03]
        end
    end

    // ----------
    // pin drive
    // ----------
    logic is_write;
    assign is_write = ~op_r[1];
    // select line: 0 for index/status, 1 for data [RULE_01] [RULE_03]
    assign bus.register_select_line = op_r[0];
    assign bus.cs_n = ~busy;
    assign bus.wr_n = ~(state_r == ST_STROBE && is_write);
    assign bus.rd_n = ~(state_r == ST_STROBE && !is_write);
    assign bus.host_dout = wdata_r;
    assign bus.host_doe = busy & is_write;
endmodule

// *** hri_bus_assertions.sv ***
// checker on the parallel bus between the two ends
`timescale 1ns/1ps
module hri_bus_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bus signals
    input wire logic cs_n,
    input wire logic register_select_line,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] host_dout,
    input wire logic host_doe,
    input wire logic [7:0] dev_dout,
    input wire logic dev_doe,
    input wire logic [7:0] data_bus
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------
    // cycle framing
    // ----------
    property p_cs; (!wr_n || !rd_n) |-> !cs_n; endproperty
    a_cs: assert property (p_cs) else $error("strobe without chip select");
    property p_wr_len; $fell(wr_n) |-> !wr_n [*2]; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe too short");
    property p_hold; $rose(wr_n) |-> !cs_n; endproperty
    a_hold: assert property (p_hold) else $error("no hold after write");
    property p_wr_stable;
        (!wr_n ##1 !wr_n) |-> $stable(register_select_line) && $stable(host_dout);
    endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("write moved");
    property p_excl; !(!rd_n && !wr_n); endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes together");
    // ----------
    // data drivers
    // ----------
    property p_doe; dev_doe == (!rd_n && !cs_n); endproperty
    a_doe: assert property (p_doe) else $error("device enable wrong");
    property p_clash; !(dev_doe && host_doe); endproperty
    a_clash: assert property (p_clash) else $error("bus contention");
    property p_rd_data; !rd_n |-> data_bus == dev_dout; endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not on bus");
    property p_wr_data; !wr_n |-> host_doe && data_bus == host_dout; endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not on bus");
    c_index: cover property (!wr_n && !register_select_line);
    c_status: cover property (!rd_n && !register_select_line);
    c_data: cover property (!rd_n && register_select_line);
endmodule

// *** testbench.sv ***
// self-checking bench driving both ends of the host register interface
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, sts;
    logic [7:0] st_in = 8'h50;
    logic pll_ok = 1'b0, warn = 1'b0, busy = 1'b0, ser = 1'b0, lin = 1'b0, ext = 1'b0;
    logic [1:0] depth = 2'h0;
    logic int_pin, ext_ev, pll_apply, soft_reset, keyscan_en, i2c_en, kz, spi_en, bus16;
    logic mask_all, mask_even;
    logic [1:0] panel_width, read_order, write_order;
    logic [6:0] burst;
    int n_errors = 0, comparisons = 0, n_sr = 0, n_pll = 0, hits;
    hri_bus_if bus ();
    hri_host u_hri_host (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(bus));
    // short debounce keeps the filter test brief
    hri_device #(.DEBOUNCE(4)) u_hri_device (.clock(clock), .rst(rst), .bus(bus),
        .wfifo_full(st_in[7]), .wfifo_empty(st_in[6]), .rfifo_full(st_in[5]),
        .rfifo_empty(st_in[4]), .core_busy(st_in[3]), .display_memory_ready(st_in[2]),
        .inhibit_state(st_in[1]), .irq_request(st_in[0]), .pll_switched(pll_ok),
        .warning_flag(warn), .host_busy(busy), .serial_host_sel(ser),
        .initial_display_run(1'b0), .linear_canvas(lin), .color_depth(depth),
        .external_interrupt_input(ext), .int_pin(int_pin), .ext_int_event(ext_ev),
        .pll_apply(pll_apply), .soft_reset(soft_reset), .panel_width(panel_width),
        .panel_spare_pins(), .keyscan_en(keyscan_en), .i2c_en(i2c_en), .key_zero_is_i2c(kz),
        .spi_en(spi_en), .bus16(bus16), .mask_high_all(mask_all), .mask_high_even(mask_even),
        .read_order(read_order), .write_order(write_order), .burst_pixels(burst));
    hri_bus_assertions u_hri_bus_assertions (.clock(clock), .rst(rst), .cs_n(bus.cs_n),
        .register_select_line(bus.register_select_line), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .host_dout(bus.host_dout), .host_doe(bus.host_doe), .dev_dout(bus.dev_dout),
        .dev_doe(bus.dev_doe), .data_bus(bus.data_bus));
    // ----------
    // tasks
    // ----------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        sts = hrdata;
        chk("hresp", hresp, 1'b0);
    endtask
    // polling status until idle; the watchdog ends a hang
    task automatic op(input logic [1:0] code, input logic [7:0] d, input logic g);
        ahb(1'b1, {24'h0, hri_pkg::AHB_CMD}, {21'h0, g, code, d});
        repeat (2) @(posedge clock);
        do ahb(1'b0, {24'h0, hri_pkg::AHB_STATUS}, 32'h0); while (sts[16] !== 1'b0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        op(hri_pkg::OP_INDEX_WRITE, idx, 1'b0);
        op(hri_pkg::OP_DATA_WRITE, v, 1'b0);
    endtask
    task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp);
        op(hri_pkg::OP_INDEX_WRITE, idx, 1'b0);
        op(hri_pkg::OP_DATA_READ, 8'h00, 1'b0);
        chk(name, sts[7:0], exp);
    endtask
    task automatic st(input logic [7:0] exp);
        op(hri_pkg::OP_STATUS_READ, 8'h00, 1'b0);
        chk("status", sts[15:8], exp);
    endtask
    // negative count means check the final event level instead
    task automatic trig(input logic [7:0] input_control, input logic a, input logic b, input int n);
        int c;
        c = 0;
        ext <= a;
        wr(hri_pkg::IDX_INPUT_CONTROL, input_control);
        repeat (12) @(posedge clock);
        ext <= b;
        repeat (12)
        begin
            @(posedge clock);
            c += ext_ev;
        end
        if (n < 0) chk("event level", ext_ev, 1'b1);
        else chk("event count", c, n);
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------
    // clock, pulse counters, watchdog
    // ----------
    always #50 clock = ~clock;
    always @(posedge clock)
    begin
        n_sr <= n_sr + soft_reset;
        n_pll <= n_pll + pll_apply;
    end
    initial
    begin
        repeat (30000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
    // ----------
    // tests
    // ----------
    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd("ccr", hri_pkg::IDX_CHIP_CONFIGURATION, 8'h48);
        rd("memory_access_control", hri_pkg::IDX_MEMORY_ACCESS_CONTROL, 8'h00);
        st(8'h50);
        for (int i = 0; i < 8; i++)
        begin
            st_in <= 8'h01 << i;
            st(8'h01 << i);
        end
        wr(hri_pkg::IDX_CHIP_CONFIGURATION, 8'hff);
        rd("ccr mask", hri_pkg::IDX_CHIP_CONFIGURATION, 8'h7f);
        chk("pins", {panel_width, keyscan_en, i2c_en, kz, spi_en, bus16}, 7'h7f);
        ser <= 1'b1;
        pll_ok <= 1'b1;
        @(posedge clock);
        chk("bus16", bus16, 1'b0);
        ser <= 1'b0;
        rd("pll ready", hri_pkg::IDX_CHIP_CONFIGURATION, 8'hff);
        for (int k = 0; k < 4; k++)
        begin
            wr(hri_pkg::IDX_CHIP_CONFIGURATION, 8'(8'h40 | (k << 3)));
            chk("panel", panel_width, k);
        end
        wr(hri_pkg::IDX_CHIP_CONFIGURATION, 8'h08);
        busy <= 1'b1;
        @(posedge clock);
        chk("wait unmasked", bus.wait_n, 1'b0);
        busy <= 1'b0;
        wr(hri_pkg::IDX_CHIP_CONFIGURATION, 8'h48);
        busy <= 1'b1;
        @(posedge clock);
        chk("wait masked", bus.wait_n, 1'b1);
        busy <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            wr(hri_pkg::IDX_MEMORY_ACCESS_CONTROL, 8'(k * 8'h52));
            chk("format", {mask_all, mask_even, read_order, write_order}, {k == 2, k == 3, 2'(k), 2'(k)});
        end
        lin <= 1'b1;
        depth <= 2'h2;
        @(posedge clock);
        chk("linear", {read_order, write_order}, 4'h0);
        chk("burst", burst, hri_pkg::BURST_24BPP);
        lin <= 1'b0;
        wr(hri_pkg::IDX_INPUT_CONTROL, 8'hff);
        rd("icr mask", hri_pkg::IDX_INPUT_CONTROL, 8'hf0);
        op(hri_pkg::OP_DATA_READ, 8'h00, 1'b0);
        chk("index kept", sts[7:0], 8'hf0);
        wr(8'h10, 8'haa);
        rd("unmapped", 8'h10, 8'h00);
        st_in <= 8'h80;
        st(8'h80);
        op(hri_pkg::OP_INDEX_WRITE, hri_pkg::IDX_INPUT_CONTROL, 1'b0);
        op(hri_pkg::OP_DATA_WRITE, 8'h00, 1'b1);
        chk("refused", sts[17], 1'b1);
        rd("icr kept", hri_pkg::IDX_INPUT_CONTROL, 8'hf0);
        st_in <= 8'h51;
        repeat (3) @(posedge clock);
        chk("int high", int_pin, 1'b1);
        wr(hri_pkg::IDX_INPUT_CONTROL, 8'h00);
        chk("int low", int_pin, 1'b0);
        st_in <= 8'h50;
        warn <= 1'b1;
        wr(hri_pkg::IDX_SOFTWARE_RESET_PLL_APPLY, 8'h81);
        chk("pulses", {n_sr[3:0], n_pll[3:0]}, 8'h11);
        rd("srr", hri_pkg::IDX_SOFTWARE_RESET_PLL_APPLY, 8'h81);
        rd("memory_access_control kept", hri_pkg::IDX_MEMORY_ACCESS_CONTROL, 8'hf6);
        trig(8'h00, 1'b1, 1'b0, -1);
        trig(8'h20, 1'b0, 1'b1, -1);
        trig(8'h10, 1'b1, 1'b0, 1);
        trig(8'h30, 1'b0, 1'b1, 1);
        trig(8'h30, 1'b1, 1'b0, 0);
        trig(8'h60, 1'b0, 1'b1, -1);
        hits = 0;
        ext <= 1'b0;
        repeat (2) @(posedge clock);
        ext <= 1'b1;
        repeat (8)
        begin
            @(posedge clock);
            hits += ext_ev;
        end
        chk("debounce", hits, 8);
        ahb(1'b0, 32'h8, 32'h0);
        chk("ahb unmapped", sts, 32'h0);
        give_verdict();
    end
endmodule
